// ---- ccwpm_top.sv ----
// Clock divider, wait states and power modes with APB registers
// Summary of operation
// - Program reads get prog_wait_cycles extra cycles
// - External RAM reads get xram_read_wait cycles
// - xram_write_stretch adds cycles to writes
// - CPU clock is oscillator divided by code
// - New divider takes effect on key write
// - Upper address byte from port2 or zero
// - Stop request bit enters STOP mode
// - Idle request bit enters IDLE mode
// - Per-pin enables for port1 wake-up
// - Normal mode runs everything as enabled
// - IDLE halts only instruction execution
// - STOP halts fast oscillator, peripherals and interrupts; slow oscillator too unless watchdog_always_on
// - Wake sources differ for IDLE and STOP
// - Wake-up clears request bit, returns normal
// - Port0 wake-up is always enabled
// - Any edge on enabled pin wakes
// - Stop wake waits oscillator plus slow clocks
`timescale 1ns/10ps
module ccwpm_top (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	input  wire logic                     clk_en,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [ccwpm_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     prog_rd_req,
	input  wire logic                     xram_rd_req,
	input  wire logic                     xram_wr_req,
	output logic                          mem_wait,
	input  wire logic [7:0]               port2_output_reg,
	output logic      [7:0]               xram_addr_hi,
	input  wire logic [7:0]               port0_in,
	input  wire logic [7:0]               port1_in,
	input  wire logic                     irq_pending,
	input  wire logic                     global_irq_enable,
	input  wire logic                     fast_osc_is_rc,
	input  wire logic                     slow_osc_tick,
	input  wire logic                     watchdog_always_on,
	output logic                          cpu_clk_en,
	output logic                          periph_clk_en,
	output logic                          irq_active,
	output logic                          fast_osc_en,
	output logic                          slow_osc_en,
	output logic                          analog_keep_en
);
	import ccwpm_pkg::*;

	ccwpm_state_type state_reg, state_next;
	logic [6:0]  wcfg_reg, wcfg_next;
	logic [2:0]  div_sel_reg, div_sel_next;
	logic [2:0]  div_act_reg, div_act_next;
	logic        page_reg, page_next;
	logic        flag_reg, flag_next;
	logic        stop_reg, stop_next;
	logic        idle_reg, idle_next;
	logic [7:0]  wake_en_reg, wake_en_next;
	logic [7:0]  p0_prev_reg, p1_prev_reg;
	logic [11:0] warm_reg, warm_next;
	logic [2:0]  slow_reg, slow_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0]  addr_hi_next;
	logic        err_reg, err_next;
	logic        wr_acc, rd_setup, port_wake, irq_wake, div_tick;
	logic [7:0]  idx;
	logic [7:0]  wdata;
	logic        wait_req;
	logic [2:0]  wait_cyc;

	// Register index decode, true when the index names a mapped register
	function automatic logic idx_mapped(input logic [7:0] i);
		idx_mapped = (i == IDX_POWER_CONTROL) || (i == IDX_WAIT_STATE_CFG) || (i == IDX_PORT1_WAKE_EN)
			|| (i == IDX_CPU_CLOCK_DIV) || (i == IDX_CLOCK_APPLY) || (i == IDX_MODE_STATUS);
	endfunction

	// Bus decode; slave answers in the first access cycle that has clk_en high
	always_comb begin
		idx = paddr[9:2];
		wdata = pwdata[7:0];
		wr_acc = psel && penable && pwrite && clk_en;
		rd_setup = psel && !penable;
		pready = clk_en;
		pslverr = err_reg;
	end

	// any edge on a port0 pin or on a port1 pin enabled in wake_en_reg counts
	always_comb begin
		port_wake = (|(port0_in ^ p0_prev_reg)) || (|((port1_in ^ p1_prev_reg) & wake_en_reg));
		irq_wake = irq_pending && global_irq_enable;
	end

	// Register writes and mode bit handling
	always_comb begin
		wcfg_next = wcfg_reg;
		div_sel_next = div_sel_reg;
		div_act_next = div_act_reg;
		page_next = page_reg;
		flag_next = flag_reg;
		stop_next = stop_reg;
		idle_next = idle_reg;
		wake_en_next = wake_en_reg;
		if (state_reg == ST_IDLE && (port_wake || irq_wake)) begin
			idle_next = 1'b0;
		end
		if (state_reg == ST_WARMUP && warm_next == 12'h000 && slow_next == 3'h0) begin
			stop_next = 1'b0;
		end
		if (wr_acc) begin
			case (idx)
				IDX_POWER_CONTROL: begin
					page_next = wdata[PWR_PAGE_BIT];
					flag_next = wdata[PWR_FLAG_BIT];
					stop_next = wdata[PWR_STOP_BIT];
					idle_next = wdata[PWR_IDLE_BIT];
				end
				IDX_WAIT_STATE_CFG: wcfg_next = wdata[6:0];
				IDX_PORT1_WAKE_EN: wake_en_next = wdata;
				IDX_CPU_CLOCK_DIV: div_sel_next = wdata[2:0];
				IDX_CLOCK_APPLY: begin
					if (wdata == CLK_APPLY_KEY) begin
						div_act_next = div_sel_reg;
					end
				end
				default: ;
			endcase
		end
	end

	// Mode state machine
	always_comb begin
		state_next = state_reg;
		warm_next = warm_reg;
		slow_next = slow_reg;
		case (state_reg)
			ST_NORMAL: begin
				if (wr_acc && idx == IDX_POWER_CONTROL && wdata[PWR_STOP_BIT]) begin
					state_next = ST_STOP;
				end else if (wr_acc && idx == IDX_POWER_CONTROL && wdata[PWR_IDLE_BIT]) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// idle wakes on port or interrupt
				if (port_wake || irq_wake) begin
					state_next = ST_NORMAL;
				end
			end
			ST_STOP: begin
				if (port_wake) begin
					state_next = ST_WARMUP;
					warm_next = fast_osc_is_rc ? WARM_RC_CYC : WARM_XTAL_CYC;
					slow_next = WARM_SLOW_CYC;
				end
			end
			ST_WARMUP: begin
				if (warm_reg != 12'h000) begin
					warm_next = warm_reg - 12'h001;
				end else if (slow_reg != 3'h0 && slow_osc_tick) begin
					slow_next = slow_reg - 3'h1;
				end
				if (warm_next == 12'h000 && slow_next == 3'h0) begin
					state_next = ST_NORMAL;
				end
			end
			default: state_next = ST_NORMAL;
		endcase
	end

	// Read data and error for the coming access phase
	always_comb begin
		rdata_next = rdata_reg;
		err_next = err_reg;
		if (rd_setup) begin
			err_next = !idx_mapped(idx) || (paddr[1:0] != 2'b00);
			case (idx)
				IDX_POWER_CONTROL: rdata_next = {28'h0000000, page_reg, flag_reg, stop_reg, idle_reg};
				IDX_WAIT_STATE_CFG: rdata_next = {25'h0000000, wcfg_reg};
				IDX_PORT1_WAKE_EN: rdata_next = {24'h000000, wake_en_reg};
				IDX_CPU_CLOCK_DIV: rdata_next = {29'h00000000, div_sel_reg};
				IDX_MODE_STATUS: rdata_next = {27'h0000000, div_act_reg, state_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
		addr_hi_next = page_reg ? 8'h00 : port2_output_reg;
	end

	// Register update
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_NORMAL;
			wcfg_reg <= WAIT_CFG_RST;
			div_sel_reg <= DIV_SEL_RST;
			div_act_reg <= DIV_SEL_RST;
			page_reg <= PAGE_SEL_RST;
			flag_reg <= 1'b0;
			stop_reg <= 1'b0;
			idle_reg <= 1'b0;
			wake_en_reg <= WAKE_EN_RST;
			p0_prev_reg <= 8'h00;
			p1_prev_reg <= 8'h00;
			warm_reg <= 12'h000;
			slow_reg <= 3'h0;
			rdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
			xram_addr_hi <= 8'h00;
		end else if (clk_en) begin
			state_reg <= state_next;
			wcfg_reg <= wcfg_next;
			div_sel_reg <= div_sel_next;
			div_act_reg <= div_act_next;
			page_reg <= page_next;
			flag_reg <= flag_next;
			stop_reg <= stop_next;
			idle_reg <= idle_next;
			wake_en_reg <= wake_en_next;
			p0_prev_reg <= port0_in;
			p1_prev_reg <= port1_in;
			warm_reg <= warm_next;
			slow_reg <= slow_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			xram_addr_hi <= addr_hi_next;
		end
	end

	assign prdata = rdata_reg;

	always_comb begin
		wait_req = prog_rd_req || xram_rd_req || (xram_wr_req && wcfg_reg[WS_STRETCH_BIT]);
		if (prog_rd_req) begin
			wait_cyc = wcfg_reg[WS_PROG_LSB +: 3];
		end else if (xram_rd_req) begin
			wait_cyc = wcfg_reg[WS_XRD_LSB +: 3];
		end else begin
			wait_cyc = WR_STRETCH_CYC;
		end
	end

	ccwpm_div u_div (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.div_code (div_act_reg),
		.tick     (div_tick)
	);

	ccwpm_wait u_wait (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.req     (wait_req),
		.cycles  (wait_cyc),
		.busy    (mem_wait)
	);

	always_comb begin
		cpu_clk_en = div_tick && (state_reg == ST_NORMAL);
		periph_clk_en = (state_reg == ST_NORMAL) || (state_reg == ST_IDLE);
		irq_active = periph_clk_en;
		fast_osc_en = (state_reg != ST_STOP);
		slow_osc_en = (state_reg != ST_STOP) || watchdog_always_on;
		analog_keep_en = 1'b1;
	end

	sequence s_key_write;
		wr_acc && idx == IDX_CLOCK_APPLY && wdata == CLK_APPLY_KEY;
	endsequence
	property p_key_apply;
		@(posedge sys_clk) disable iff (!rst_b) s_key_write |=> div_act_reg == $past(div_sel_reg);
	endproperty
	a_key_apply: assert property (p_key_apply) else $error("key did not apply divider");
	property p_bad_key;
		@(posedge sys_clk) disable iff (!rst_b)
			(wr_acc && idx == IDX_CLOCK_APPLY && wdata != CLK_APPLY_KEY) |=> $stable(div_act_reg);
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key changed divider");
	property p_stop_enter;
		@(posedge sys_clk) disable iff (!rst_b) (state_reg == ST_NORMAL && wr_acc && idx == IDX_POWER_CONTROL
			&& wdata[PWR_STOP_BIT]) |=> state_reg == ST_STOP && !fast_osc_en;
	endproperty
	a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
	property p_idle_enter;
		@(posedge sys_clk) disable iff (!rst_b) (state_reg == ST_NORMAL && wr_acc && idx == IDX_POWER_CONTROL
			&& wdata[1:0] == 2'b01) |=> state_reg == ST_IDLE && !cpu_clk_en && periph_clk_en;
	endproperty
	a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");
	property p_stop_gate;
		@(posedge sys_clk) disable iff (!rst_b) state_reg == ST_STOP |-> !periph_clk_en && !irq_active && !cpu_clk_en;
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("stop left units running");
	property p_idle_wake;
		@(posedge sys_clk) disable iff (!rst_b)
			(clk_en && state_reg == ST_IDLE && irq_wake && !wr_acc) |=> state_reg == ST_NORMAL && !idle_reg;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");
	property p_stop_irq;
		@(posedge sys_clk) disable iff (!rst_b) (state_reg == ST_STOP && !port_wake) |=> state_reg == ST_STOP;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("stop left without port change");
	property p_warm_rc;
		@(posedge sys_clk) disable iff (!rst_b) (clk_en && state_reg == ST_STOP && port_wake && fast_osc_is_rc)
			|=> state_reg == ST_WARMUP && warm_reg == WARM_RC_CYC && slow_reg == WARM_SLOW_CYC;
	endproperty
	a_warm_rc: assert property (p_warm_rc) else $error("warm-up count wrong");
	property p_page;
		@(posedge sys_clk) disable iff (!rst_b)
			clk_en |=> xram_addr_hi == ($past(page_reg) ? 8'h00 : $past(port2_output_reg));
	endproperty
	a_page: assert property (p_page) else $error("upper address byte wrong");
endmodule

// ---- ccwpm_pkg.sv ----
// Shared constants and types of the clock, wait and power-mode controller
package ccwpm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
	localparam logic [7:0] IDX_WAIT_STATE_CFG = 8'h8e;
	localparam logic [7:0] IDX_PORT1_WAKE_EN  = 8'h91;
	localparam logic [7:0] IDX_CPU_CLOCK_DIV  = 8'he5;
	localparam logic [7:0] IDX_CLOCK_APPLY    = 8'he6;
	localparam logic [7:0] IDX_MODE_STATUS    = 8'he7;
	localparam int         ADDR_W             = 12;
	// Field positions
	localparam int PWR_IDLE_BIT   = 0;
	localparam int PWR_STOP_BIT   = 1;
	localparam int PWR_FLAG_BIT   = 2;
	localparam int PWR_PAGE_BIT   = 3;
	localparam int WS_XRD_LSB     = 0;
	localparam int WS_STRETCH_BIT = 3;
	localparam int WS_PROG_LSB    = 4;
	// Reset values
	localparam logic [6:0] WAIT_CFG_RST = 7'h71;
	localparam logic [2:0] DIV_SEL_RST  = 3'h7;
	localparam logic       PAGE_SEL_RST = 1'b1;
	localparam logic [7:0] WAKE_EN_RST  = 8'h00;
	// Apply key and extra cycles of a stretched external write
	localparam logic [7:0] CLK_APPLY_KEY   = 8'h69;
	localparam logic [2:0] WR_STRETCH_CYC  = 3'h1;
	// Warm-up counts after a stop wake-up
	localparam logic [11:0] WARM_XTAL_CYC = 12'd2048;
	localparam logic [11:0] WARM_RC_CYC   = 12'd64;
	localparam logic [2:0]  WARM_SLOW_CYC = 3'd5;
	// Divider counter width
	localparam int DIV_CNT_W = 7;
	typedef enum logic [1:0] {ST_NORMAL, ST_IDLE, ST_STOP, ST_WARMUP} ccwpm_state_type;
endpackage

// ---- ccwpm_div.sv ----
// CPU clock enable divider, divide by 128 down to 1
`timescale 1ns/10ps
module ccwpm_div (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic [2:0] div_code,
	output logic            tick
);
	import ccwpm_pkg::*;

	logic [DIV_CNT_W-1:0] cnt_reg;
	logic [DIV_CNT_W-1:0] cnt_next;

	// Terminal count: 2**(7-code) - 1
	function automatic logic [DIV_CNT_W-1:0] div_limit(input logic [2:0] code);
		div_limit = 7'h7f >> code;
	endfunction

	always_comb begin
		tick = (cnt_reg >= div_limit(div_code));
		cnt_next = tick ? 7'h00 : cnt_reg + 7'h01;
	end

	// Counter register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 7'h00;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
		end
	end

	property p_div_full;
		@(posedge sys_clk) disable iff (!rst_b) (clk_en && div_code == 3'h7) |-> tick;
	endproperty
	a_div_full: assert property (p_div_full) else $error("divide by one lost ticks");
	// Divide by two must skip the cycle after each tick
	property p_div_half;
		@(posedge sys_clk) disable iff (!rst_b) (clk_en && tick && div_code == 3'h6) |=> (!tick || div_code != 3'h6);
	endproperty
	a_div_half: assert property (p_div_half) else $error("divide by two ticked twice in a row");
endmodule

// ---- ccwpm_wait.sv ----
// Wait-state counter for memory accesses
`timescale 1ns/10ps
module ccwpm_wait (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic       req,
	input  wire logic [2:0] cycles,
	output logic            busy
);
	import ccwpm_pkg::*;

	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;

	// Load on request, count down while busy
	always_comb begin
		busy = (cnt_reg != 3'h0);
		if (req && !busy) begin
			cnt_next = cycles;
		end else if (busy) begin
			cnt_next = cnt_reg - 3'h1;
		end else begin
			cnt_next = cnt_reg;
		end
	end

	// Counter register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 3'h0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
		end
	end

	sequence s_two_wait;
		busy ##1 busy;
	endsequence
	property p_wait_two;
		@(posedge sys_clk) disable iff (!rst_b) (clk_en && req && !busy && cycles == 3'h2) |=> s_two_wait;
	endproperty
	a_wait_two: assert property (p_wait_two) else $error("two wait cycles not inserted");
endmodule

// ---- ccwpm_core_model.sv ----
// Processor core stand-in that issues memory accesses and times the stalls
`timescale 1ns/10ps
module ccwpm_core_model (
	input  wire logic sys_clk,
	input  wire logic mem_wait,
	output logic      prog_rd_req,
	output logic      xram_rd_req,
	output logic      xram_wr_req
);
	// Idle request lines
	initial begin
		prog_rd_req = 1'b0;
		xram_rd_req = 1'b0;
		xram_wr_req = 1'b0;
	end

	// One access: k 0 program read, 1 external read, 2 external write; n counts stall cycles
	task automatic access(input int k, output int n);
		int g;
		g = 0;
		n = 0;
		// Never request while a stall is still running
		while (mem_wait === 1'b1 && g < 20) begin
			@(posedge sys_clk);
			g++;
		end
		@(posedge sys_clk);
		prog_rd_req <= (k == 0);
		xram_rd_req <= (k == 1);
		xram_wr_req <= (k == 2);
		@(posedge sys_clk);
		prog_rd_req <= 1'b0;
		xram_rd_req <= 1'b0;
		xram_wr_req <= 1'b0;
		#1;
		while (mem_wait === 1'b1 && n < 20) begin
			n++;
			@(posedge sys_clk);
			#1;
		end
	endtask
endmodule

// ---- ccwpm_top_bench.sv ----
// Self-checking bench of the clock, wait and power-mode controller
`timescale 1ns/10ps
module ccwpm_top_bench;
	import ccwpm_pkg::*;
	logic              sys_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              prog_rd_req, xram_rd_req, xram_wr_req, mem_wait, slow_osc_tick;
	logic [7:0]        port2_output_reg, xram_addr_hi, port0_in, port1_in, v;
	logic              irq_pending, global_irq_enable, fast_osc_is_rc, watchdog_always_on;
	logic              cpu_clk_en, periph_clk_en, irq_active, fast_osc_en, slow_osc_en, analog_keep_en;
	logic [2:0]        tk;
	int                failures, checked, n, m, lo;
	int                exp_reg[int];

	// Design and processor-side model
	ccwpm_top ccwpm_top_inst (.sys_clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .prog_rd_req, .xram_rd_req, .xram_wr_req, .mem_wait, .port2_output_reg,
		.xram_addr_hi, .port0_in, .port1_in, .irq_pending, .global_irq_enable, .fast_osc_is_rc,
		.slow_osc_tick, .watchdog_always_on, .cpu_clk_en, .periph_clk_en, .irq_active, .fast_osc_en,
		.slow_osc_en, .analog_keep_en);
	ccwpm_core_model ccwpm_core_model_inst (.sys_clk, .mem_wait, .prog_rd_req, .xram_rd_req, .xram_wr_req);

	// Clock, and a slow-oscillator tick every eight cycles
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		tk <= tk + 3'h1;
		slow_osc_tick <= (tk == 3'h0);
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask

	// One APB transfer; read data and error land in rd and err
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= ($urandom() & 32'hffffff00) | {24'h0, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		// Ends when pready is high; only the hang guard bounds this wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write and keep the register model in step
	task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [7:0] mask);
		apb(1'b1, idx, val);
		exp_reg[idx] = val & mask;
	endtask

	task automatic rdc(input logic [7:0] idx);
		apb(1'b0, idx, 8'h00);
		chk($sformatf("register %h", idx), rd, exp_reg[idx]);
		chk("slave error", {31'h0, err}, 32'h0);
	endtask

	task automatic period(output int p);
		int g;
		g = 0;
		p = 0;
		step();
		while (cpu_clk_en !== 1'b1 && g < 300) begin
			step();
			g++;
		end
		do begin
			step();
			p++;
		end while (cpu_clk_en !== 1'b1 && p < 300);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#200000;
		failures++;
		finish_test();
	end

	initial begin
		failures = 0;
		checked = 0;
		sys_clk = 1'b0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		port2_output_reg = 8'h00;
		port0_in = 8'h00;
		port1_in = 8'h00;
		irq_pending = 1'b0;
		global_irq_enable = 1'b0;
		fast_osc_is_rc = 1'b1;
		watchdog_always_on = 1'b0;
		tk = 3'h0;
		slow_osc_tick = 1'b0;
		void'($urandom(32'h4b7a1cbe));
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		exp_reg[IDX_POWER_CONTROL] = 32'h08;
		exp_reg[IDX_WAIT_STATE_CFG] = 32'h71;
		exp_reg[IDX_PORT1_WAKE_EN] = 32'h00;
		exp_reg[IDX_CPU_CLOCK_DIV] = 32'h07;
		exp_reg[IDX_CLOCK_APPLY] = 32'h00;
		exp_reg[IDX_MODE_STATUS] = 32'h1c;
		foreach (exp_reg[i]) rdc(8'(i));
		chk("normal clocks", {periph_clk_en, irq_active, fast_osc_en, slow_osc_en}, 4'hf);
		apb(1'b0, 8'h10, 8'h00);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset values done");
		for (int r = 0; r < 8; r++) begin
			v = 8'($urandom());
			wr(IDX_PORT1_WAKE_EN, v, 8'hff);
			wr(IDX_WAIT_STATE_CFG, {v[7], r[2:0], v[0], ~r[2:0]}, 8'h7f);
			wr(IDX_POWER_CONTROL, v & 8'h0c, 8'h0c);
			foreach (exp_reg[i]) rdc(8'(i));
			ccwpm_core_model_inst.access(0, n);
			chk("program read wait", n, r);
			ccwpm_core_model_inst.access(1, n);
			chk("external read wait", n, 7 - r);
			ccwpm_core_model_inst.access(2, n);
			chk("external write stretch", n, v[0] ? WR_STRETCH_CYC : 3'h0);
			port2_output_reg <= 8'($urandom());
			repeat (3) step();
			chk("upper address byte", xram_addr_hi, v[3] ? 8'h00 : port2_output_reg);
		end
		$display("test registers and waits done");
		for (int c = 0; c < 8; c++) begin
			wr(IDX_CPU_CLOCK_DIV, 8'(c), 8'h07);
			v = 8'($urandom());
			if (v == CLK_APPLY_KEY) v = 8'h00;
			wr(IDX_CLOCK_APPLY, v, 8'h00);
			rdc(IDX_MODE_STATUS);
			wr(IDX_CLOCK_APPLY, CLK_APPLY_KEY, 8'h00);
			exp_reg[IDX_MODE_STATUS] = c << 2;
			rdc(IDX_MODE_STATUS);
			period(n);
			chk("cpu clock period", n, 1 << (7 - c));
		end
		$display("test divider done");
		wr(IDX_PORT1_WAKE_EN, 8'h04, 8'hff);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, IDX_POWER_CONTROL, 8'(exp_reg[IDX_POWER_CONTROL] | 1));
			irq_pending <= 1'b1;
			step();
			port1_in <= port1_in ^ 8'h01;
			m = 0;
			repeat (4) begin
				step();
				m += cpu_clk_en;
			end
			chk("cpu ticks in idle", m, 0);
			chk("idle clocks", {periph_clk_en, irq_active, fast_osc_en, slow_osc_en}, 4'hf);
			exp_reg[IDX_MODE_STATUS] = 32'h1d;
			rdc(IDX_MODE_STATUS);
			if (s == 0) global_irq_enable <= 1'b1;
			else if (s == 1) port1_in <= port1_in ^ 8'h04;
			else port0_in <= port0_in ^ 8'h80;
			repeat (4) step();
			exp_reg[IDX_MODE_STATUS] = 32'h1c;
			rdc(IDX_MODE_STATUS);
			rdc(IDX_POWER_CONTROL);
			irq_pending <= 1'b0;
			global_irq_enable <= 1'b0;
		end
		$display("test idle done");
		for (int r = 0; r < 2; r++) begin
			fast_osc_is_rc <= r[0];
			watchdog_always_on <= r[0];
			apb(1'b1, IDX_POWER_CONTROL, 8'(exp_reg[IDX_POWER_CONTROL] | 2));
			irq_pending <= 1'b1;
			global_irq_enable <= 1'b1;
			repeat (2) step();
			port1_in <= port1_in ^ 8'h01;
			repeat (4) step();
			chk("stop outputs", {cpu_clk_en, periph_clk_en, irq_active, fast_osc_en, slow_osc_en,
				analog_keep_en}, {4'h0, r[0], 1'b1});
			exp_reg[IDX_MODE_STATUS] = 32'h1e;
			rdc(IDX_MODE_STATUS);
			port0_in <= port0_in ^ 8'h01;
			n = 0;
			do begin
				step();
				n++;
			end while (cpu_clk_en !== 1'b1 && n < 3000);
			lo = r ? 64 : 2048;
			chk("warm-up span", {31'h0, n >= lo + 33 && n <= lo + 48}, 32'h1);
			exp_reg[IDX_MODE_STATUS] = 32'h1c;
			rdc(IDX_MODE_STATUS);
			rdc(IDX_POWER_CONTROL);
			irq_pending <= 1'b0;
			global_irq_enable <= 1'b0;
		end
		$display("test stop done");
		finish_test();
	end
endmodule
